// >>> rtl/bgc_pkg.sv
// constants, field layout and shared types of the beamformer global control block
// assumes a register port already decoded from the serial framing, one word per access
package bgc_pkg;
  localparam logic [4:0] ADDR_FIRE_CTRL = 5'h1a;
  localparam logic [4:0] ADDR_REF_SEL = 5'h1b;
  localparam logic [4:0] ADDR_PAT_LO = 5'h08;
  localparam logic [4:0] ADDR_PAT_HI = 5'h19;
  localparam logic [13:0] FIRE_CTRL_RESET = 14'h047f;
  localparam logic [7:0] REF_SEL_RESET = 8'h00;
  localparam logic [63:0] CW_PATTERN = 64'h5555555555555555;
  localparam logic [7:0] DIV_ZERO_TICKS = 8'h80;
  // clk_sys is the master tick, so the lead is counted in ticks, not in time
  localparam int START_CYCLES = 6;
  localparam logic [6:0] LEN_CW = 7'h40;

  typedef struct packed {
    logic reserved;
    logic continuousWave;
    logic invertFireEnable;
    logic synthEnable;
    logic [6:0] bitPeriodDivider;
    logic [2:0] patternLength;
  } bgc_ctrl_t;

  typedef enum logic [1:0] {IDLE, LEAD, SEND, WAIT_RX} bgc_state_t;
endpackage

// >>> rtl/bgc_global_control.sv
// global fire control and reference select registers with a single-channel fire sequencer
// assumes clk_sys stands in for the master clock tick and patterns arrive already stored
`timescale 1ns/1ps
module bgc_global_control import bgc_pkg::*; #(
  parameter int PAT_W = 64
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic [4:0] regAddr,
  input wire logic [13:0] regWrData,
  input wire logic fireTrigger,
  input wire logic serialLatchStrobe,
  input wire logic rxDone,
  input wire logic [PAT_W-1:0] patP,
  input wire logic [PAT_W-1:0] patN,
  output logic [13:0] regRdData,
  output logic patWrEn,
  output logic synthEnable,
  output logic refSingleEnded,
  output logic pulseP,
  output logic pulseN,
  output logic firing
);
  if (PAT_W != 64) begin : gWidthCheck
    $error("pattern width must be 64");
  end

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [6:0] patLen(input logic [2:0] code);
    case (code)
      3'h0: patLen = 7'h04;
      3'h1: patLen = 7'h08;
      3'h2: patLen = 7'h10;
      3'h3: patLen = 7'h18;
      3'h4: patLen = 7'h20;
      3'h5: patLen = 7'h28;
      3'h6: patLen = 7'h30;
      default: patLen = 7'h40;
    endcase
  endfunction

  function automatic logic [7:0] bitTicks(input logic [6:0] div);
    // zero means 128 ticks per bit, 256 per alternating period
    bitTicks = (div == 7'h00) ? DIV_ZERO_TICKS : {1'b0, div};
  endfunction

  function automatic logic inPatRange(input logic [4:0] a);
    inPatRange = (a >= ADDR_PAT_LO) && (a <= ADDR_PAT_HI);
  endfunction

  // ****************************************
  // registers
  // ****************************************
  bgc_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic [13:0] rd_nxt;
  logic patWr_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    sel_nxt = sel_r;
    // reserved bits are stored as written; software keeps them zero
    if (regWrEn && regAddr == ADDR_FIRE_CTRL) begin
      ctrl_nxt = bgc_ctrl_t'(regWrData);
    end else if (regWrEn && regAddr == ADDR_REF_SEL) begin
      sel_nxt = regWrData[7:0];
    end
    if (regAddr == ADDR_FIRE_CTRL) begin
      rd_nxt = ctrl_nxt;
    end else if (regAddr == ADDR_REF_SEL) begin
      rd_nxt = {6'h00, sel_nxt};
    end else begin
      rd_nxt = 14'h0000;
    end
    patWr_nxt = regWrEn && inPatRange(regAddr) && !ctrl_r.continuousWave;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= bgc_ctrl_t'(FIRE_CTRL_RESET);
      sel_r <= REF_SEL_RESET;
      regRdData <= FIRE_CTRL_RESET;
      patWrEn <= 1'b0;
      synthEnable <= FIRE_CTRL_RESET[10];
      refSingleEnded <= REF_SEL_RESET[0];
    end else begin
      ctrl_r <= ctrl_nxt;
      sel_r <= sel_nxt;
      regRdData <= rd_nxt;
      patWrEn <= patWr_nxt;
      synthEnable <= ctrl_nxt.synthEnable;
      refSingleEnded <= sel_nxt[0];
    end
  end

  // ****************************************
  // fire sequencer
  // ****************************************
  bgc_state_t state_r, state_nxt;
  logic [7:0] lead_r, lead_nxt;
  logic [7:0] bitCnt_r, bitCnt_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic inv_r, inv_nxt;
  logic pulseP_nxt, pulseN_nxt, firing_nxt;
  logic trigPrev_r;
  logic trigRise;
  logic [6:0] curLen;
  logic [63:0] srcP, srcN;
  logic lastTick;

  assign trigRise = fireTrigger && !trigPrev_r;
  // continuous wave always runs the full fixed pattern regardless of the length field
  assign curLen = ctrl_r.continuousWave ? LEN_CW : patLen(ctrl_r.patternLength);
  assign srcP = ctrl_r.continuousWave ? CW_PATTERN : patP;
  assign srcN = ctrl_r.continuousWave ? ~CW_PATTERN : patN;
  assign lastTick = (bitCnt_r == 8'h00) && ({1'b0, idx_r} == curLen - 7'h01);

  always_comb begin
    state_nxt = state_r;
    lead_nxt = lead_r;
    bitCnt_nxt = bitCnt_r;
    idx_nxt = idx_r;
    inv_nxt = inv_r;
    case (state_r)
      IDLE: begin
        if (trigRise) begin
          state_nxt = LEAD;
          lead_nxt = 8'(START_CYCLES - 1);
          inv_nxt = 1'b0;
        end
      end
      LEAD: begin
        if (lead_r == 8'h00) begin
          state_nxt = SEND;
          idx_nxt = 6'h00;
          bitCnt_nxt = bitTicks(ctrl_r.bitPeriodDivider) - 8'h01;
        end else begin
          lead_nxt = lead_r - 8'h01;
        end
      end
      SEND: begin
        if (ctrl_r.continuousWave && !fireTrigger) begin
          state_nxt = IDLE;
        end else if (bitCnt_r != 8'h00) begin
          bitCnt_nxt = bitCnt_r - 8'h01;
        end else begin
          bitCnt_nxt = bitTicks(ctrl_r.bitPeriodDivider) - 8'h01;
          if (!lastTick) begin
            idx_nxt = idx_r + 6'h01;
          end else if (ctrl_r.continuousWave) begin
            idx_nxt = 6'h00;
          end else if (ctrl_r.invertFireEnable && !inv_r) begin
            state_nxt = WAIT_RX;
          end else begin
            state_nxt = IDLE;
          end
        end
      end
      WAIT_RX: begin
        if (rxDone) begin
          state_nxt = LEAD;
          lead_nxt = 8'(START_CYCLES - 1);
          inv_nxt = 1'b1;
        end
      end
      default: state_nxt = IDLE;
    endcase
    // a dropped strobe mid-sequence abandons the pending inverted firing
    if (ctrl_r.invertFireEnable && !serialLatchStrobe && state_r != IDLE) begin
      state_nxt = IDLE;
      inv_nxt = 1'b0;
    end
    pulseP_nxt = (state_nxt == SEND) && (srcP[idx_nxt] ^ inv_nxt);
    pulseN_nxt = (state_nxt == SEND) && (srcN[idx_nxt] ^ inv_nxt);
    firing_nxt = (state_nxt != IDLE);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IDLE;
      lead_r <= 8'h00;
      bitCnt_r <= 8'h00;
      idx_r <= 6'h00;
      inv_r <= 1'b0;
      trigPrev_r <= 1'b0;
      pulseP <= 1'b0;
      pulseN <= 1'b0;
      firing <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lead_r <= lead_nxt;
      bitCnt_r <= bitCnt_nxt;
      idx_r <= idx_nxt;
      inv_r <= inv_nxt;
      trigPrev_r <= fireTrigger;
      pulseP <= pulseP_nxt;
      pulseN <= pulseN_nxt;
      firing <= firing_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  localparam int LEAD_D = START_CYCLES + 1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence enterSend;
    state_r != SEND ##1 state_r == SEND;
  endsequence

  cw_write_block_a: assert property (regWrEn && inPatRange(regAddr) && ctrl_r.continuousWave |=> !patWrEn) else $error("pattern write passed in cw");
  start_delay_a: assert property (state_r == IDLE && trigRise && serialLatchStrobe |-> ##LEAD_D state_r == SEND || !serialLatchStrobe) else $error("firing start delay wrong");
  synth_follow_a: assert property (regWrEn && regAddr == ADDR_FIRE_CTRL |=> synthEnable == $past(regWrData[10])) else $error("synth enable not updated");
  ref_sel_a: assert property (regWrEn && regAddr == ADDR_REF_SEL |=> refSingleEnded == $past(regWrData[0])) else $error("reference select not updated");
  single_shot_a: assert property (state_r == SEND && lastTick && !ctrl_r.continuousWave && (!ctrl_r.invertFireEnable || inv_r) |=> state_r == IDLE && !firing) else $error("single shot did not stop");
  cw_repeat_a: assert property (state_r == SEND && lastTick && ctrl_r.continuousWave && fireTrigger |=> state_r == SEND && idx_r == 6'h00) else $error("cw did not wrap");
  cw_stop_a: assert property (state_r == SEND && ctrl_r.continuousWave && !fireTrigger |=> state_r == IDLE ##1 !firing) else $error("cw did not stop");
  plain_bit_a: assert property (state_r == SEND && !inv_r |-> pulseP == srcP[idx_r]) else $error("plain bit wrong");
  invert_bit_a: assert property (state_r == SEND && inv_r |-> pulseP == !srcP[idx_r]) else $error("inverted bit wrong");
  bit_period_a: assert property (enterSend |-> bitCnt_r == bitTicks(ctrl_r.bitPeriodDivider) - 8'h01) else $error("bit period load wrong");
  strobe_abort_a: assert property (ctrl_r.invertFireEnable && state_r == WAIT_RX && !serialLatchStrobe |=> state_r == IDLE) else $error("strobe drop ignored");
endmodule

// >>> test/bgc_host_model.sv
// host controller model: register writes, stored patterns, trigger, strobe and receive end
// assumes the bench calls its tasks just after a clock edge
`timescale 1ns/1ps
module bgc_host_model import bgc_pkg::*; (
  input wire logic clk_sys,
  output logic regWrEn,
  output logic [4:0] regAddr,
  output logic [13:0] regWrData,
  output logic fireTrigger,
  output logic serialLatchStrobe,
  output logic rxDone,
  output logic [63:0] patP,
  output logic [63:0] patN
);
  // ****************************************
  // host side drivers
  // ****************************************
  initial begin
    regWrEn = 1'b0;
    regAddr = ADDR_FIRE_CTRL;
    regWrData = 14'h0000;
    fireTrigger = 1'b0;
    serialLatchStrobe = 1'b1;
    rxDone = 1'b0;
    patP = 64'h0;
    patN = 64'h0;
  end
  // reserved bits forced to zero, the device gives no guarantee otherwise
  task automatic wr(input logic [4:0] a, input logic [13:0] d);
    @(posedge clk_sys);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= (a == ADDR_REF_SEL) ? {13'h0000, d[0]} : {1'b0, d[12:0]};
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic sel(input logic [4:0] a);
    regAddr <= a;
  endtask
  task automatic setPat(input logic [63:0] p, input logic [63:0] q, input int len);
    patP <= p & ((64'h1 << len) - 64'h1);
    patN <= q & ((64'h1 << len) - 64'h1);
  endtask
  // trigger held by caller until firing ends; no serial traffic meanwhile
  task automatic drive(input logic t, input logic s, input logic r);
    fireTrigger <= t;
    serialLatchStrobe <= s;
    rxDone <= r;
  endtask
endmodule

// >>> test/bgc_global_control_test.sv
// self-checking bench for the global control block
// assumes the host model drives every design input except clock and reset
`timescale 1ns/1ps
module bgc_global_control_test import bgc_pkg::*;;
  // ****************************************
  // bench
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic regWrEn, fireTrigger, serialLatchStrobe, rxDone;
  logic [4:0] regAddr;
  logic [13:0] regWrData, regRdData;
  logic [63:0] patP, patN;
  logic patWrEn, synthEnable, refSingleEnded, pulseP, pulseN, firing;
  logic capP [0:2047];
  logic capN [0:2047];
  int err_total = 0;
  int samples_checked = 0;
  int n;
  int lens [8] = '{4, 8, 16, 24, 32, 40, 48, 64};
  always #20 clk_sys = ~clk_sys;
  bgc_host_model h (.clk_sys(clk_sys), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .fireTrigger(fireTrigger), .serialLatchStrobe(serialLatchStrobe),
    .rxDone(rxDone), .patP(patP), .patN(patN));
  bgc_global_control dut (.clk_sys(clk_sys), .rst_n(rst_n), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .fireTrigger(fireTrigger),
    .serialLatchStrobe(serialLatchStrobe), .rxDone(rxDone), .patP(patP), .patN(patN),
    .regRdData(regRdData), .patWrEn(patWrEn), .synthEnable(synthEnable),
    .refSingleEnded(refSingleEnded), .pulseP(pulseP), .pulseN(pulseN), .firing(firing));
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [13:0] exp);
    @(posedge clk_sys);
    h.sel(a);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(regRdData, exp);
  endtask
  task automatic wp(input logic [4:0] a, input logic e);
    h.wr(a, 14'h0000);
    #1;
    chk(patWrEn, e);
  endtask
  function automatic bgc_ctrl_t ctl(logic cw, logic invert_fire_enable, logic pll, logic [6:0] dv,
    logic [2:0] pl);
    return bgc_ctrl_t'{1'b0, cw, invert_fire_enable, pll, dv, pl};
  endfunction
  // counts firing cycles; 999 disables the receive pulse, trigger drop or strobe drop
  // each drive waits for a rising edge, so the host reacts one cycle after it counts
  task automatic shot(input int rxAt, input int stopAt, input int abortAt);
    int i;
    n = 0;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      h.drive(n < stopAt, n < abortAt, n == rxAt);
      #1;
      if (firing === 1'b1) begin
        capP[n] = pulseP;
        capN[n] = pulseN;
        n++;
      end else if (n > 0) break;
    end
    if (i == 3000) begin
      err_total++;
      test_done();
    end
    repeat (3) @(posedge clk_sys);
    #1;
    chk(firing, 1'b0);
    @(posedge clk_sys);
    h.drive(1'b0, 1'b1, 1'b0);
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_FIRE_CTRL, FIRE_CTRL_RESET);
    chk(synthEnable, 1'b1);
    chk(refSingleEnded, 1'b0);
    rd(ADDR_REF_SEL, {6'h00, REF_SEL_RESET});
    h.wr(ADDR_REF_SEL, 14'h0001);
    rd(ADDR_REF_SEL, 14'h0001);
    chk(refSingleEnded, 1'b1);
    h.wr(ADDR_FIRE_CTRL, ctl(1'b0, 1'b0, 1'b0, 7'h01, 3'h0));
    rd(ADDR_FIRE_CTRL, 14'h0008);
    chk(synthEnable, 1'b0);
    wp(ADDR_PAT_LO, 1'b1);
    wp(ADDR_PAT_HI, 1'b1);
    wp(5'h07, 1'b0);
    h.wr(ADDR_FIRE_CTRL, ctl(1'b1, 1'b0, 1'b1, 7'h01, 3'h0));
    wp(ADDR_PAT_LO, 1'b0);
    wp(ADDR_PAT_HI, 1'b0);
    shot(999, 150, 999);
    chk(n, 151);
    chk(capP[START_CYCLES - 1], 1'b0);
    for (int j = START_CYCLES; j < 151; j++) begin
      chk(capP[j], CW_PATTERN[(j - START_CYCLES) % 64]);
      chk(capN[j], !CW_PATTERN[(j - START_CYCLES) % 64]);
    end
    h.setPat(64'hb, 64'h4, 4);
    for (int c = 0; c < 8; c++) begin
      h.wr(ADDR_FIRE_CTRL, ctl(1'b0, 1'b0, 1'b1, 7'h01, 3'(c)));
      shot(999, 999, 999);
      chk(n, START_CYCLES + lens[c]);
    end
    h.wr(ADDR_FIRE_CTRL, ctl(1'b0, 1'b0, 1'b1, 7'h03, 3'h0));
    shot(999, 999, 999);
    chk(n, START_CYCLES + 12);
    for (int j = 0; j < 12; j++) begin
      chk(capP[START_CYCLES + j], patP[j / 3]);
      chk(capN[START_CYCLES + j], patN[j / 3]);
    end
    h.wr(ADDR_FIRE_CTRL, ctl(1'b0, 1'b0, 1'b1, 7'h00, 3'h0));
    shot(999, 999, 999);
    chk(n, START_CYCLES + 512);
    chk(capP[START_CYCLES + 255], 1'b1);
    chk(capP[START_CYCLES + 256], 1'b0);
    h.wr(ADDR_FIRE_CTRL, ctl(1'b0, 1'b1, 1'b1, 7'h02, 3'h0));
    shot(START_CYCLES + 9, 999, 999);
    chk(n, 2 * START_CYCLES + 18);
    for (int k = 0; k < 4; k++) begin
      chk(capP[START_CYCLES + 2 * k], patP[k]);
      chk(capP[2 * START_CYCLES + 10 + 2 * k], !patP[k]);
    end
    shot(999, 999, START_CYCLES + 11);
    chk(n, START_CYCLES + 12);
    test_done();
  end
endmodule
